// [hw/bds_setpoint_seq.sv]
// Purpose: set-point sequencer top, register file, power-good and fault masking
// Assumes: inputs synchronous to ref_clk; Avalon-MM byte address, one-cycle answer
// Notes: channel 0 core buck one, 1 core buck two, 2 buck three, 3 buck four pair,
//        4 buck five
//
// Contract
// - sleep low: core target is normal code
// - sleep high: core target is sleep code
// - software set-point change ramps, never jumps
// - sleep transitions step at ramp speed interval
// - speed codes give 2, 4, 8, 16 us
// - buck three and five: 4 us steps
// - buck four: 8 or 16 us by range
// - buck three, four, five hold sleep codes
// - core power good high once target reached
// - power good low during ramp or limit
// - limit outside ramp holds power good low
// - over-current masked during a ramp
// - boost voltage code picks 5.000 to 5.150 V
// - boost mode fields decode off/pfm/auto/aps
// - auto mode follows load between pfm, aps
// - boost mode fields reset to auto
// - sleep input selects sleep behaviour
`include "bds_defs.svh"
module bds_setpoint_seq (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_req,
  input wire logic [1:0] cur_limit,
  input wire logic [4:0] over_current_in,
  input wire logic boost_light_load,
  output logic [1:0] power_good_out,
  output logic [4:0] over_current_fault,
  output logic [4:0] ramp_active,
  output logic [29:0] applied_code_out,
  output logic [12:0] boost_voltage_mv,
  output logic [1:0] boost_mode_out
);
  localparam int NCH = 5;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  bds_pkg::bds_code_t normal_setpoint_code [NCH];
  bds_pkg::bds_code_t sleep_setpoint_code [NCH];
  logic [1:0] ramp_speed_select [2];
  logic [1:0] buck4_high_range_select;
  logic [1:0] boost_voltage_select;
  bds_pkg::bds_boost_mode_e boost_normal_mode_select;
  bds_pkg::bds_boost_mode_e boost_sleep_mode_select;

  bds_pkg::bds_code_t applied [NCH];
  logic [NCH-1:0] ramping;
  logic [31:0] rd_word;
  logic wr_fire;
  logic [3:0] ch_idx;

  assign wr_fire = avs_write && !avs_waitrequest;
  assign ch_idx = avs_address[5:2];

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // a write lands only on the edge that completes the bus cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        normal_setpoint_code[i] <= `BDS_SETPT_RST;
        sleep_setpoint_code[i] <= `BDS_SETPT_RST;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_idx == 4'(i)) begin
          if (avs_byteenable[0]) begin
            normal_setpoint_code[i] <= avs_writedata[`BDS_F_NORMAL_LSB +: 6];
          end
          if (avs_byteenable[1]) begin
            sleep_setpoint_code[i] <= avs_writedata[`BDS_F_SLEEP_LSB +: 6];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ramp_speed_select[0] <= `BDS_SPEED_RST;
      ramp_speed_select[1] <= `BDS_SPEED_RST;
      buck4_high_range_select <= `BDS_HI_RST;
    end else if (wr_fire && avs_byteenable[2]) begin
      if ({ch_idx, 2'h0} == `BDS_OFS_CORE1) begin
        ramp_speed_select[0] <= avs_writedata[`BDS_F_SPEED_LSB +: 2];
      end
      if ({ch_idx, 2'h0} == `BDS_OFS_CORE2) begin
        ramp_speed_select[1] <= avs_writedata[`BDS_F_SPEED_LSB +: 2];
      end
      if ({ch_idx, 2'h0} == `BDS_OFS_BUCK4) begin
        buck4_high_range_select <= avs_writedata[`BDS_F_SPEED_LSB +: 2];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      boost_voltage_select <= `BDS_BVOLT_RST;
      boost_normal_mode_select <= bds_pkg::bds_boost_mode_e'(`BDS_BMODE_RST);
      boost_sleep_mode_select <= bds_pkg::bds_boost_mode_e'(`BDS_BMODE_RST);
    end else if (wr_fire && {ch_idx, 2'h0} == `BDS_OFS_BOOST) begin
      if (avs_byteenable[0]) begin
        boost_voltage_select <= avs_writedata[`BDS_F_BVOLT_LSB +: 2];
        boost_normal_mode_select <=
          bds_pkg::bds_boost_mode_e'(avs_writedata[`BDS_F_BNMODE_LSB +: 2]);
      end
      if (avs_byteenable[1]) begin
        boost_sleep_mode_select <=
          bds_pkg::bds_boost_mode_e'(avs_writedata[`BDS_F_BSMODE_LSB +: 2]);
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h0;
    case ({ch_idx, 2'h0})
      `BDS_OFS_CORE1, `BDS_OFS_CORE2, `BDS_OFS_BUCK3, `BDS_OFS_BUCK4,
      `BDS_OFS_BUCK5: begin
        for (int i = 0; i < NCH; i++) begin
          if (ch_idx == 4'(i)) begin
            rd_word[`BDS_F_NORMAL_LSB +: 6] = normal_setpoint_code[i];
            rd_word[`BDS_F_SLEEP_LSB +: 6] = sleep_setpoint_code[i];
          end
        end
        if ({ch_idx, 2'h0} == `BDS_OFS_CORE1) begin
          rd_word[`BDS_F_SPEED_LSB +: 2] = ramp_speed_select[0];
        end
        if ({ch_idx, 2'h0} == `BDS_OFS_CORE2) begin
          rd_word[`BDS_F_SPEED_LSB +: 2] = ramp_speed_select[1];
        end
        if ({ch_idx, 2'h0} == `BDS_OFS_BUCK4) begin
          rd_word[`BDS_F_SPEED_LSB +: 2] = buck4_high_range_select;
        end
      end
      `BDS_OFS_BOOST: begin
        rd_word[`BDS_F_BVOLT_LSB +: 2] = boost_voltage_select;
        rd_word[`BDS_F_BNMODE_LSB +: 2] = boost_normal_mode_select;
        rd_word[`BDS_F_BSMODE_LSB +: 2] = boost_sleep_mode_select;
      end
      `BDS_OFS_STATUS: begin
        rd_word[`BDS_F_ST_RAMP_LSB +: 5] = ramp_active;
        rd_word[`BDS_F_ST_PG_LSB +: 2] = power_good_out;
        rd_word[`BDS_F_ST_OC_LSB +: 5] = over_current_fault;
        rd_word[`BDS_F_ST_BMODE_LSB +: 2] = boost_mode_out;
      end
      `BDS_OFS_APPLIED_A: begin
        rd_word = {2'h0, applied[3], 2'h0, applied[2], 2'h0, applied[1], 2'h0, applied[0]};
      end
      `BDS_OFS_APPLIED_B: begin
        rd_word[5:0] = applied[4];
      end
      default: rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // fixed one-cycle answer; unmapped reads give zero, unmapped writes are dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_word;
    end
  end

  // ----------------------------------------
  // ramp channels
  // ----------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    bds_ramp_if rif();
    bds_pkg::bds_interval_t ival;

    // sleep request swaps in the sleep code
    assign rif.target = sleep_req ? sleep_setpoint_code[g]
                                  : normal_setpoint_code[g];
    if (g < 2) begin : g_core
      always_comb begin
        case (ramp_speed_select[g])
          2'h0: ival = 9'(`BDS_CYC(`BDS_STEP_2US_NS));
          2'h1: ival = 9'(`BDS_CYC(`BDS_STEP_4US_NS));
          2'h2: ival = 9'(`BDS_CYC(`BDS_STEP_8US_NS));
          default: ival = 9'(`BDS_CYC(`BDS_STEP_16US_NS));
        endcase
      end
    end else if (g == 3) begin : g_b4
      // range code 00 takes the faster rate, any other code the slower
      assign ival = (buck4_high_range_select == 2'h0) ? 9'(`BDS_CYC(`BDS_STEP_8US_NS))
                                                      : 9'(`BDS_CYC(`BDS_STEP_16US_NS));
    end else begin : g_b35
      assign ival = 9'(`BDS_CYC(`BDS_STEP_4US_NS));
    end
    assign rif.interval = ival;
    assign applied[g] = rif.applied;
    assign ramping[g] = rif.ramping;
    assign applied_code_out[6*g +: 6] = rif.applied;

    bds_ramp_chan u_chan (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .rif(rif)
    );

    // a ramp can trip the limit on its own; keep it out of the fault path
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        over_current_fault[g] <= 1'b0;
        ramp_active[g] <= 1'b0;
      end else begin
        over_current_fault[g] <= over_current_in[g] && !ramping[g];
        ramp_active[g] <= ramping[g];
      end
    end
  end

  // ----------------------------------------
  // power good
  // ----------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_pg
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        power_good_out[p] <= 1'b0;
      end else begin
        power_good_out[p] <= !ramping[p] && !cur_limit[p];
      end
    end
  end

  // ----------------------------------------
  // boost converter
  // ----------------------------------------
  bds_boost_if bif();
  assign bif.volt_sel = boost_voltage_select;
  assign bif.normal_mode = boost_normal_mode_select;
  assign bif.sleep_mode = boost_sleep_mode_select;
  assign bif.sleep = sleep_req;
  assign bif.light_load = boost_light_load;
  assign boost_voltage_mv = bif.vout_mv;
  assign boost_mode_out = bif.active_mode;

  bds_boost_ctrl u_boost (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bif(bif)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  a_bus_one_cycle: assert property (s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
  a_pg_ramp_low: assert property (ramping[0] |=> !power_good_out[0])
    else $error("power good high during a ramp");
  a_pg_limit_low: assert property (cur_limit[1] |=> !power_good_out[1])
    else $error("power good high under current limit");
  // rstn in the antecedent: the edge that releases reset still loads the reset value
  a_pg_reached: assert property (rstn && !ramping[0] && !cur_limit[0] |=>
    power_good_out[0])
    else $error("power good low at target");
  a_oc_masked: assert property (ramping[2] |=> !over_current_fault[2])
    else $error("over-current not masked during ramp");
  a_oc_passed: assert property (over_current_in[4] && !ramping[4] |=>
    over_current_fault[4])
    else $error("over-current lost outside a ramp");
  a_sleep_settle: assert property (sleep_req && !ramping[0] |->
    applied[0] == sleep_setpoint_code[0])
    else $error("settled core code not the sleep code");
  a_normal_settle: assert property (!sleep_req && !ramping[1] |->
    applied[1] == normal_setpoint_code[1])
    else $error("settled core code not the normal code");
  a_sleep_toward: assert property ($past(sleep_req) && $changed(applied[0]) |->
    (applied[0] > $past(applied[0])) == ($past(applied[0]) < $past(sleep_setpoint_code[0])))
    else $error("core ramp not heading for the sleep code");
  a_normal_toward: assert property (!$past(sleep_req) && $changed(applied[1]) |->
    (applied[1] > $past(applied[1])) == ($past(applied[1]) < $past(normal_setpoint_code[1])))
    else $error("core ramp not heading for the normal code");
  a_core_interval: assert property ($changed(applied[0]) && ramp_speed_select[0] == 2'h0 &&
    $stable(ramp_speed_select[0]) |=> $stable(applied[0]) [*8])
    else $error("core step faster than the interval");
endmodule : bds_setpoint_seq

// [hw/bds_defs.svh]
// Purpose: offsets, field positions, reset values and step timing of the set-point sequencer
// Assumes: 20 MHz ref_clk
// Notes: definitions only
`ifndef BDS_DEFS_SVH
`define BDS_DEFS_SVH

// ----------------------------------------
// clock and step timing
// ----------------------------------------
`define BDS_CLK_MHZ 20
`define BDS_STEP_2US_NS 2000
`define BDS_STEP_4US_NS 4000
`define BDS_STEP_8US_NS 8000
`define BDS_STEP_16US_NS 16000
// least times, exact at 20 MHz; round up for other rates
`define BDS_CYC(ns) (((ns) * `BDS_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BDS_OFS_CORE1 6'h00
`define BDS_OFS_CORE2 6'h04
`define BDS_OFS_BUCK3 6'h08
`define BDS_OFS_BUCK4 6'h0c
`define BDS_OFS_BUCK5 6'h10
`define BDS_OFS_BOOST 6'h14
`define BDS_OFS_STATUS 6'h18
`define BDS_OFS_APPLIED_A 6'h1c
`define BDS_OFS_APPLIED_B 6'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define BDS_F_NORMAL_LSB 0
`define BDS_F_SLEEP_LSB 8
`define BDS_F_SPEED_LSB 16
`define BDS_F_BVOLT_LSB 0
`define BDS_F_BNMODE_LSB 4
`define BDS_F_BSMODE_LSB 8
`define BDS_F_ST_RAMP_LSB 0
`define BDS_F_ST_PG_LSB 8
`define BDS_F_ST_OC_LSB 16
`define BDS_F_ST_BMODE_LSB 24

// ----------------------------------------
// reset values
// ----------------------------------------
`define BDS_SETPT_RST 6'h00
`define BDS_SPEED_RST 2'h1
`define BDS_HI_RST 2'h0
`define BDS_BVOLT_RST 2'h0
`define BDS_BMODE_RST 2'h2

// ----------------------------------------
// boost output decode
// ----------------------------------------
`define BDS_BOOST_BASE_MV 13'h1388
`define BDS_BOOST_STEP_MV 13'h0032

`endif

// [hw/bds_pkg.sv]
// Purpose: shared types of the set-point sequencer
// Assumes: nothing
// Notes: constants live in bds_defs.svh
package bds_pkg;
  typedef logic [5:0] bds_code_t;
  typedef logic [8:0] bds_interval_t;
  typedef enum logic [1:0] {
    bds_mode_off = 2'h0,
    bds_mode_pfm = 2'h1,
    bds_mode_auto = 2'h2,
    bds_mode_aps = 2'h3
  } bds_boost_mode_e;
endpackage : bds_pkg

// [hw/bds_links_if.sv]
// Purpose: carriers between the top and its ramp and boost modules
// Assumes: one clock
// Notes: no clocking blocks
interface bds_ramp_if;
  bds_pkg::bds_code_t target;
  bds_pkg::bds_interval_t interval;
  bds_pkg::bds_code_t applied;
  logic ramping;
  modport chan(input target, input interval, output applied, output ramping);
  modport ctrl(output target, output interval, input applied, input ramping);
endinterface : bds_ramp_if

interface bds_boost_if;
  logic [1:0] volt_sel;
  bds_pkg::bds_boost_mode_e normal_mode;
  bds_pkg::bds_boost_mode_e sleep_mode;
  logic sleep;
  logic light_load;
  logic [12:0] vout_mv;
  bds_pkg::bds_boost_mode_e active_mode;
  modport conv(input volt_sel, input normal_mode, input sleep_mode, input sleep,
               input light_load, output vout_mv, output active_mode);
  modport ctrl(output volt_sel, output normal_mode, output sleep_mode, output sleep,
               output light_load, input vout_mv, input active_mode);
endinterface : bds_boost_if

// [hw/bds_ramp_chan.sv]
// Purpose: one regulator ramp, one code step per interval toward the target
// Assumes: interval of at least 9 cycles
// Notes: a new target redirects from the present code
`include "bds_defs.svh"
module bds_ramp_chan (
  input wire logic ref_clk,
  input wire logic rstn,
  bds_ramp_if.chan rif
);
  // ----------------------------------------
  // interval timer and stepping
  // ----------------------------------------
  bds_pkg::bds_interval_t tick;
  logic step_due;

  assign step_due = (rif.applied != rif.target) && (tick == rif.interval - 9'h001);
  assign rif.ramping = (rif.applied != rif.target);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick <= 9'h000;
    end else if (rif.applied == rif.target || step_due) begin
      tick <= 9'h000;
    end else begin
      tick <= tick + 9'h001;
    end
  end

  // never a jump: one code per interval
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rif.applied <= `BDS_SETPT_RST;
    end else if (step_due) begin
      if (rif.applied < rif.target) begin
        rif.applied <= rif.applied + 6'h01;
      end else begin
        rif.applied <= rif.applied - 6'h01;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_step;
    $changed(rif.applied);
  endsequence

  a_step_unit_size: assert property (s_step |->
    (6'(rif.applied - $past(rif.applied)) == 6'h01) ||
    (6'($past(rif.applied) - rif.applied) == 6'h01))
    else $error("applied code moved by more than one step");
  a_step_min_gap: assert property (s_step |=> $stable(rif.applied) [*8])
    else $error("two steps closer than the interval");
  a_step_on_due: assert property (step_due |=> s_step)
    else $error("due step not taken");
  a_stop_at_target: assert property (!rif.ramping && $stable(rif.target) |=>
    $stable(rif.applied))
    else $error("applied code moved with no ramp");
endmodule : bds_ramp_chan

// [hw/bds_boost_ctrl.sv]
// Purpose: boost converter voltage and mode decode
// Assumes: light_load is a synchronous load-detect level
// Notes: auto resolves to pfm on light load, else aps
`include "bds_defs.svh"
module bds_boost_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  bds_boost_if.conv bif
);
  bds_pkg::bds_boost_mode_e sel_mode;

  // sleep request picks the sleep mode field
  assign sel_mode = bif.sleep ? bif.sleep_mode : bif.normal_mode;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bif.vout_mv <= `BDS_BOOST_BASE_MV;
    end else begin
      bif.vout_mv <= `BDS_BOOST_BASE_MV + 13'(bif.volt_sel) * `BDS_BOOST_STEP_MV;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bif.active_mode <= bds_pkg::bds_mode_off;
    end else begin
      case (sel_mode)
        bds_pkg::bds_mode_off: bif.active_mode <= bds_pkg::bds_mode_off;
        bds_pkg::bds_mode_pfm: bif.active_mode <= bds_pkg::bds_mode_pfm;
        bds_pkg::bds_mode_aps: bif.active_mode <= bds_pkg::bds_mode_aps;
        bds_pkg::bds_mode_auto: begin
          bif.active_mode <= bif.light_load ? bds_pkg::bds_mode_pfm
                                            : bds_pkg::bds_mode_aps;
        end
        default: bif.active_mode <= bds_pkg::bds_mode_off;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_boost_auto_load: assert property (rstn && sel_mode == bds_pkg::bds_mode_auto &&
    bif.light_load |=> bif.active_mode == bds_pkg::bds_mode_pfm)
    else $error("auto mode did not pick pfm on light load");
  a_boost_top_volt: assert property (bif.volt_sel == 2'h3 |=> bif.vout_mv == 13'h141e)
    else $error("boost voltage code 3 not 5150 mV");
endmodule : bds_boost_ctrl

// [sim/bds_proc_model.sv]
// Purpose: processor-side model raising the sleep event toward the sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: sleep_cmd comes from the bench scenario
module bds_proc_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sleep_cmd,
  output logic sleep_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // sleep event
  // ----------------------------------------
  // registered so the level only moves just after an edge, like a system event
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sleep_req <= 1'b0;
    end else begin
      sleep_req <= sleep_cmd;
    end
  end
endmodule : bds_proc_model

// [sim/testbench.sv]
// Purpose: self-checking bench of the set-point sequencer
// Assumes: 20 MHz ref_clk, one-cycle bus answer
// Notes: ramp times get a few cycles of slack for bus and sync latency
`include "bds_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {logic [31:0] wd; logic ll; logic [12:0] mv; logic [1:0] md;} bds_row_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic sleep_cmd = 1'b0;
  logic sleep_req;
  logic [1:0] cur_limit = 2'h0;
  logic [4:0] over_current_in = 5'h00;
  logic boost_light_load = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] power_good_out;
  logic [4:0] over_current_fault;
  logic [4:0] ramp_active;
  logic [29:0] applied_code_out;
  logic [12:0] boost_voltage_mv;
  logic [1:0] boost_mode_out;
  int n_fail = 0;
  int n_checks = 0;
  int cyc;
  logic [31:0] rd;
  bds_row_s rows [0:4] = '{
    '{32'h00000200, 1'b0, 13'h1388, 2'h0},
    '{32'h00000211, 1'b0, 13'h13ba, 2'h1},
    '{32'h00000222, 1'b1, 13'h13ec, 2'h1},
    '{32'h00000223, 1'b0, 13'h141e, 2'h3},
    '{32'h00000232, 1'b1, 13'h13ec, 2'h3}};

  always #25 ref_clk = ~ref_clk;

  bds_proc_model pm_u (.ref_clk(ref_clk), .rstn(rstn), .sleep_cmd(sleep_cmd),
    .sleep_req(sleep_req));
  bds_setpoint_seq dut_u (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_req(sleep_req), .cur_limit(cur_limit),
    .over_current_in(over_current_in), .boost_light_load(boost_light_load),
    .power_good_out(power_good_out), .over_current_fault(over_current_fault),
    .ramp_active(ramp_active), .applied_code_out(applied_code_out),
    .boost_voltage_mv(boost_voltage_mv), .boost_mode_out(boost_mode_out));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request held until waitrequest is sampled low at a rising edge, released right there
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic ramp(input int ch, input logic [5:0] tgt, input int lo, input string nm);
    cyc = 0;
    while (applied_code_out[6*ch +: 6] !== tgt && cyc < 2000) begin
      @(negedge ref_clk);
      cyc++;
    end
    chk(nm, cyc >= lo && cyc <= lo + 4, 1'b1);
  endtask : ramp

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("pg_rst", power_good_out, 2'h3);
    chk("mv_rst", boost_voltage_mv, 13'h1388);
    chk("mode_rst", boost_mode_out, 2'h3);
    bus(1'b0, `BDS_OFS_CORE1, 32'h0);
    chk("core1_rst", rd, 32'h00010000);
    bus(1'b0, `BDS_OFS_BOOST, 32'h0);
    chk("boost_rst", rd, 32'h00000220);
    bus(1'b0, 6'h24, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      boost_light_load <= rows[i].ll;
      bus(1'b1, `BDS_OFS_BOOST, rows[i].wd);
      repeat (3) @(negedge ref_clk);
      chk("boost_mv", boost_voltage_mv, rows[i].mv);
      chk("boost_mode", boost_mode_out, rows[i].md);
    end
    // over-current raised before the ramp must be hidden from the ramp start until it ends
    @(posedge ref_clk);
    over_current_in <= 5'h11;
    bus(1'b1, `BDS_OFS_CORE1, 32'h00000002);
    repeat (2) @(negedge ref_clk);
    chk("ramp_flag", ramp_active[0], 1'b1);
    chk("pg_ramp", power_good_out[0], 1'b0);
    chk("oc_mask", over_current_fault[0], 1'b0);
    ramp(0, 6'h02, 78, "core1_up");
    repeat (2) @(negedge ref_clk);
    chk("pg_done", power_good_out[0], 1'b1);
    chk("oc_open", over_current_fault[0], 1'b1);
    chk("ramp_done", ramp_active[0], 1'b0);
    bus(1'b1, `BDS_OFS_CORE1, 32'h00000004);
    ramp(0, 6'h03, 38, "core1_mid");
    bus(1'b1, `BDS_OFS_CORE1, 32'h00000002);
    ramp(0, 6'h02, 35, "core1_redirect");
    bus(1'b1, `BDS_OFS_CORE2, 32'h00030100);
    bus(1'b1, `BDS_OFS_BUCK3, 32'h00000300);
    bus(1'b1, `BDS_OFS_BOOST, 32'h00000100);
    sleep_cmd <= 1'b1;
    ramp(2, 6'h03, 240, "buck3_sleep");
    ramp(1, 6'h01, 78, "core2_sleep");
    chk("core1_sleep", applied_code_out[5:0], 6'h00);
    chk("boost_sleep", boost_mode_out, 2'h1);
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    ramp(2, 6'h00, 240, "buck3_wake");
    chk("core1_wake", applied_code_out[5:0], 6'h02);
    bus(1'b1, `BDS_OFS_BUCK4, 32'h00000001);
    ramp(3, 6'h01, 159, "buck4_lo");
    bus(1'b1, `BDS_OFS_BUCK4, 32'h00010002);
    ramp(3, 6'h02, 319, "buck4_hi");
    @(posedge ref_clk);
    cur_limit <= 2'h2;
    repeat (3) @(negedge ref_clk);
    chk("pg_limit", power_good_out, 2'h1);
    @(posedge ref_clk);
    cur_limit <= 2'h0;
    repeat (3) @(negedge ref_clk);
    chk("pg_clear", power_good_out, 2'h3);
    bus(1'b1, `BDS_OFS_STATUS, 32'hffffffff);
    bus(1'b0, `BDS_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h00110300);
    print_verdict();
  end
endmodule : testbench
